/* dfc_consts.vh */
`ifndef DFC_CONSTS_VH
`define DFC_CONSTS_VH

// word offsets on the register bus (byte address)
`define DFC_ADR_CTRL 8'h00
`define DFC_ADR_REJ 8'h04
`define DFC_ADR_AVG 8'h08
`define DFC_ADR_RATE 8'h0c
`define DFC_ADR_SFMIN 8'h10
`define DFC_ADR_STAT 8'h14
`define DFC_ADR_DIST 8'h18
`define DFC_ADR_POLL 8'h1c

// control fields
`define DFC_CTRL_REJ_LO 0
`define DFC_CTRL_AVG_LO 2
`define DFC_CTRL_LIM_LO 4
`define DFC_CTRL_POLL 8

// rejection parameter fields
`define DFC_REJ_M_LO 0
`define DFC_REJ_X_LO 12
`define DFC_REJ_Y_LO 16

// stage option codes
`define DFC_REJ_NONE 2'h0
`define DFC_REJ_CLOSE 2'h1
`define DFC_REJ_FAR 2'h2
`define DFC_REJ_STAB 2'h3
`define DFC_AVG_NONE 2'h0
`define DFC_AVG_BOX 2'h1
`define DFC_AVG_RUN 2'h2
`define DFC_LIM_NONE 2'h0
`define DFC_LIM_RATE 2'h1
`define DFC_LIM_SF 2'h2

// reset values: running average of 50, other stages off
`define DFC_CTRL_RST 32'h0000_0008
`define DFC_REJ_RST 32'h0007_4002
`define DFC_AVG_RST 32'h0000_0032
`define DFC_RATE_RST 32'h0000_0001
`define DFC_SFMIN_RST 32'h0000_0001

// stability window is +/- 1/16 (6.25 %) of the newest value
`define DFC_STAB_SHIFT 4
`define DFC_HIST_MAX 7

`endif

/* dfc_filter.v */
// Notes on behaviour
// RULE_01 - stages run reject, average, limit; each bypassable
// RULE_02 - first valid measurement seeds every stage; only the rejection history and the limiter are seeded, not averaging
// RULE_03 - closest-of-M passes smallest of M
// RULE_04 - farthest-of-M passes largest of M
// RULE_05 - M-based rejection emits once per M inputs
// RULE_06 - accept if X of Y within 6.25%
// RULE_07 - unstable measurements discarded, nothing produced
// RULE_08 - X ranges 1..7, Y ranges 2..7
// RULE_09 - stable measurements pass with no delay
// RULE_10 - output resumes once criterion met again
// RULE_11 - later stages freeze while target unstable
// RULE_12 - rejection output feeds averaging or bypasses it
// RULE_13 - boxcar: mean of N, restart, N 2..255
// RULE_14 - running: mean of latest N, every input
// RULE_15 - rate limit clamps change both directions
// RULE_16 - slow-fast starts slow, then accelerates
// RULE_17 - limiter output is the sensor distance
// RULE_18 - poll mode refuses stability, running, slow-fast
// RULE_19 - default: running average 50, rest off
// RULE_20 - each poll runs M*N measurements, queues extra
// RULE_21 - running average divides by count so far
`timescale 1ns/10ps
`include "dfc_consts.vh"

module dfc_filter #(
  parameter DW = 16,
  parameter NMAX = 255
) (
  input wire clk,
  input wire srst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire meas_valid,
  input wire [DW-1:0] meas_dist,
  input wire poll,
  output reg dist_valid,
  output reg [DW-1:0] dist_out,
  output reg target_stable,
  output reg pass_busy
);

  localparam SW = DW + 8;

  reg [31:0] reg_ctrl;
  reg [31:0] reg_rej;
  reg [31:0] reg_avg;
  reg [31:0] reg_rate;
  reg [31:0] reg_sfmin;

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] sel;
    integer k;
    begin
      merge = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (sel[k]) begin
          merge[k*8 +: 8] = nw[k*8 +: 8];
        end
      end
    end
  endfunction

  // |a - b| <= b/16
  function near;
    input [DW-1:0] a;
    input [DW-1:0] b;
    reg [DW-1:0] d;
    begin
      d = (a > b) ? a - b : b - a;
      near = (d <= (b >> `DFC_STAB_SHIFT));
    end
  endfunction

  // move cur toward tgt by at most step
  function [DW-1:0] slew;
    input [DW-1:0] cur;
    input [DW-1:0] tgt;
    input [DW-1:0] step;
    begin
      if (tgt > cur) begin
        slew = (tgt - cur > step) ? cur + step : tgt;
      end else begin
        slew = (cur - tgt > step) ? cur - step : tgt;
      end
    end
  endfunction

  wire [1:0] rej_sel = reg_ctrl[`DFC_CTRL_REJ_LO +: 2];
  wire [1:0] avg_sel = reg_ctrl[`DFC_CTRL_AVG_LO +: 2];
  wire [1:0] lim_sel = reg_ctrl[`DFC_CTRL_LIM_LO +: 2];
  wire poll_mode = reg_ctrl[`DFC_CTRL_POLL];
  wire [9:0] m_cfg = reg_rej[`DFC_REJ_M_LO +: 10];
  wire [2:0] x_cfg = reg_rej[`DFC_REJ_X_LO +: 3];
  wire [2:0] y_cfg = reg_rej[`DFC_REJ_Y_LO +: 3];
  wire [7:0] n_cfg = reg_avg[7:0];
  // out-of-range settings are clamped rather than refused
  wire [9:0] m_use = (m_cfg < 10'h002) ? 10'h002 : (m_cfg > 10'h3e7) ? 10'h3e7 : m_cfg; // RULE_03
  wire [2:0] x_use = (x_cfg == 3'h0) ? 3'h1 : x_cfg; // RULE_08
  wire [2:0] y_use = (y_cfg < 3'h2) ? 3'h2 : y_cfg; // RULE_08
  wire [7:0] n_use = (n_cfg < 8'h02) ? 8'h02 : n_cfg; // RULE_13

  // disallowed options fall back to bypass in poll mode
  wire bad_rej = poll_mode && (rej_sel == `DFC_REJ_STAB); // RULE_18
  wire bad_avg = poll_mode && (avg_sel == `DFC_AVG_RUN); // RULE_18
  wire bad_lim = poll_mode && (lim_sel == `DFC_LIM_SF); // RULE_18
  wire cfg_err = bad_rej | bad_avg | bad_lim;
  wire [1:0] rej_m = bad_rej ? `DFC_REJ_NONE : rej_sel;
  wire [1:0] avg_m = bad_avg ? `DFC_AVG_NONE : avg_sel;
  wire [1:0] lim_m = (bad_lim || lim_sel == 2'h3) ? `DFC_LIM_NONE : lim_sel;
  wire filt_any = (rej_m != `DFC_REJ_NONE) | (avg_m != `DFC_AVG_NONE) | (lim_m != `DFC_LIM_NONE);

  // bus slave: ack one cycle after request, write commits on the ack edge
  wire bus_req = wb_cyc_i & wb_stb_i;
  wire bus_wr = bus_req & wb_ack_o & wb_we_i;
  wire cfg_wr = bus_wr && (wb_adr_i == `DFC_ADR_CTRL || wb_adr_i == `DFC_ADR_REJ || wb_adr_i == `DFC_ADR_AVG);
  wire poll_wr = bus_wr && (wb_adr_i == `DFC_ADR_POLL);

  reg seeded;
  reg pass_pend;
  reg [17:0] pass_cnt;

  always @(posedge clk) begin
    if (srst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      reg_ctrl <= `DFC_CTRL_RST; // RULE_19
      reg_rej <= `DFC_REJ_RST;
      reg_avg <= `DFC_AVG_RST; // RULE_19
      reg_rate <= `DFC_RATE_RST;
      reg_sfmin <= `DFC_SFMIN_RST;
    end else begin
      wb_ack_o <= bus_req & ~wb_ack_o;
      if (bus_req & ~wb_ack_o) begin
        case (wb_adr_i)
          `DFC_ADR_CTRL: wb_dat_o <= reg_ctrl;
          `DFC_ADR_REJ: wb_dat_o <= reg_rej;
          `DFC_ADR_AVG: wb_dat_o <= reg_avg;
          `DFC_ADR_RATE: wb_dat_o <= reg_rate;
          `DFC_ADR_SFMIN: wb_dat_o <= reg_sfmin;
          `DFC_ADR_STAT: wb_dat_o <= {27'h0, pass_pend, cfg_err, pass_busy, target_stable, seeded};
          `DFC_ADR_DIST: wb_dat_o <= {{(32-DW){1'b0}}, dist_out};
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
      if (bus_wr) begin
        case (wb_adr_i)
          `DFC_ADR_CTRL: reg_ctrl <= merge(reg_ctrl, wb_dat_i, wb_sel_i) & 32'h0000_013f;
          `DFC_ADR_REJ: reg_rej <= merge(reg_rej, wb_dat_i, wb_sel_i) & 32'h0007_73ff;
          `DFC_ADR_AVG: reg_avg <= merge(reg_avg, wb_dat_i, wb_sel_i) & 32'h0000_00ff;
          `DFC_ADR_RATE: reg_rate <= merge(reg_rate, wb_dat_i, wb_sel_i) & 32'h0000_ffff;
          `DFC_ADR_SFMIN: reg_sfmin <= merge(reg_sfmin, wb_dat_i, wb_sel_i) & 32'h0000_ffff;
          default: reg_ctrl <= reg_ctrl;
        endcase
      end
    end
  end

  // poll passes: M*N raw measurements per poll
  wire [9:0] pass_m = (rej_m == `DFC_REJ_CLOSE || rej_m == `DFC_REJ_FAR) ? m_use : 10'h001;
  wire [7:0] pass_n = (avg_m == `DFC_AVG_BOX) ? n_use : 8'h01;
  wire [17:0] pass_need = pass_m * pass_n; // RULE_20
  wire poll_evt = poll | poll_wr;
  wire take = meas_valid & (~poll_mode | pass_busy);
  wire pass_end = poll_mode & pass_busy & take & (pass_cnt + 18'h00001 >= pass_need);

  always @(posedge clk) begin
    if (srst || !poll_mode) begin
      pass_busy <= 1'b0;
      pass_pend <= 1'b0;
      pass_cnt <= 18'h00000;
    end else begin
      if (pass_end) begin
        pass_cnt <= 18'h00000;
        pass_busy <= pass_pend | poll_evt; // RULE_20
        pass_pend <= 1'b0;
      end else begin
        if (take) begin
          pass_cnt <= pass_cnt + 18'h00001;
        end
        if (poll_evt) begin
          if (pass_busy) begin
            pass_pend <= 1'b1; // RULE_20
          end else begin
            pass_busy <= 1'b1;
          end
        end
      end
    end
  end

  // rejection stage
  reg [DW-1:0] hist [0:`DFC_HIST_MAX-1];
  wire [`DFC_HIST_MAX-1:0] hit;
  genvar gi;
  generate
    for (gi = 0; gi < `DFC_HIST_MAX; gi = gi + 1) begin : g_hit
      assign hit[gi] = (gi < y_use) && near(hist[gi], meas_dist); // RULE_06
    end
  endgenerate

  function [2:0] ones;
    input [`DFC_HIST_MAX-1:0] v;
    integer k;
    begin
      ones = 3'h0;
      for (k = 0; k < `DFC_HIST_MAX; k = k + 1) begin
        ones = ones + {2'h0, v[k]};
      end
    end
  endfunction

  wire first = take & ~seeded & filt_any;
  wire stab_ok = first | (ones(hit) >= x_use); // RULE_06

  reg r_v;
  reg [DW-1:0] r_d;
  reg [DW-1:0] ext;
  reg [9:0] m_cnt;
  integer hi;

  always @(posedge clk) begin
    if (srst) begin
      seeded <= 1'b0;
      target_stable <= 1'b1;
      r_v <= 1'b0;
      r_d <= {DW{1'b0}};
      ext <= {DW{1'b0}};
      m_cnt <= 10'h000;
      for (hi = 0; hi < `DFC_HIST_MAX; hi = hi + 1) begin
        hist[hi] <= {DW{1'b0}};
      end
    end else begin
      r_v <= 1'b0;
      if (first) begin
        seeded <= 1'b1;
      end
      if (cfg_wr) begin
        m_cnt <= 10'h000;
      end else if (take) begin
        for (hi = 1; hi < `DFC_HIST_MAX; hi = hi + 1) begin
          hist[hi] <= first ? meas_dist : hist[hi-1]; // RULE_02
        end
        hist[0] <= meas_dist;
        case (rej_m)
          `DFC_REJ_CLOSE, `DFC_REJ_FAR: begin
            if (m_cnt == 10'h000 || (rej_m == `DFC_REJ_CLOSE ? meas_dist < ext : meas_dist > ext)) begin
              ext <= meas_dist; // RULE_03 RULE_04
            end
            if (m_cnt + 10'h001 >= m_use) begin
              m_cnt <= 10'h000;
              r_v <= 1'b1; // RULE_05
              r_d <= (m_cnt == 10'h000 || (rej_m == `DFC_REJ_CLOSE ? meas_dist < ext : meas_dist > ext))
                     ? meas_dist : ext;
            end else begin
              m_cnt <= m_cnt + 10'h001;
            end
          end
          `DFC_REJ_STAB: begin
            target_stable <= stab_ok; // RULE_10
            if (stab_ok) begin
              r_v <= 1'b1; // RULE_09
              r_d <= meas_dist;
            end
            // otherwise dropped and nothing downstream moves; RULE_07 RULE_11
          end
          default: begin
            target_stable <= 1'b1;
            r_v <= 1'b1; // RULE_01
            r_d <= meas_dist;
          end
        endcase
      end
    end
  end

  // averaging stage
  reg [DW-1:0] ring [0:NMAX-1];
  reg [7:0] ring_ptr;
  reg [7:0] run_cnt;
  reg [SW-1:0] run_sum;
  reg [SW-1:0] box_sum;
  reg [7:0] box_cnt;
  reg a_v;
  reg [DW-1:0] a_d;

  wire run_full = (run_cnt >= n_use);
  wire [SW-1:0] run_next = run_sum + {{8{1'b0}}, r_d} - (run_full ? {{8{1'b0}}, ring[ring_ptr]} : {SW{1'b0}});
  wire [7:0] run_div = run_full ? n_use : run_cnt + 8'h01; // RULE_21
  wire [SW-1:0] run_q = run_next / {{(SW-8){1'b0}}, run_div}; // RULE_14
  wire [SW-1:0] box_next = box_sum + {{8{1'b0}}, r_d};
  wire [SW-1:0] box_q = box_next / {{(SW-8){1'b0}}, n_use}; // RULE_13
  integer ri;

  always @(posedge clk) begin
    if (srst || cfg_wr) begin
      ring_ptr <= 8'h00;
      run_cnt <= 8'h00;
      run_sum <= {SW{1'b0}};
      box_sum <= {SW{1'b0}};
      box_cnt <= 8'h00;
      a_v <= 1'b0;
      a_d <= {DW{1'b0}};
      for (ri = 0; ri < NMAX; ri = ri + 1) begin
        ring[ri] <= {DW{1'b0}};
      end
    end else begin
      a_v <= 1'b0;
      if (r_v) begin
        case (avg_m)
          `DFC_AVG_BOX: begin
            if (box_cnt + 8'h01 >= n_use) begin
              box_sum <= {SW{1'b0}};
              box_cnt <= 8'h00;
              a_v <= 1'b1; // RULE_13
              a_d <= box_q[DW-1:0];
            end else begin
              box_sum <= box_next;
              box_cnt <= box_cnt + 8'h01;
            end
          end
          `DFC_AVG_RUN: begin
            ring[ring_ptr] <= r_d;
            ring_ptr <= (ring_ptr + 8'h01 >= n_use) ? 8'h00 : ring_ptr + 8'h01;
            run_sum <= run_next;
            if (!run_full) begin
              run_cnt <= run_cnt + 8'h01;
            end
            a_v <= 1'b1; // RULE_14
            a_d <= run_q[DW-1:0];
          end
          default: begin
            a_v <= 1'b1; // RULE_12
            a_d <= r_d;
          end
        endcase
      end
    end
  end

  // limiting stage; step sizes are distance units per update
  reg [DW-1:0] sf_step;
  reg [DW-1:0] sf_last;
  wire [DW-1:0] sf_min = (reg_sfmin[DW-1:0] == {DW{1'b0}}) ? {{(DW-1){1'b0}}, 1'b1} : reg_sfmin[DW-1:0];
  wire [DW-1:0] sf_dbl = sf_step[DW-1] ? {DW{1'b1}} : {sf_step[DW-2:0], 1'b0};

  always @(posedge clk) begin
    if (srst) begin
      dist_valid <= 1'b0;
      dist_out <= {DW{1'b0}};
      sf_step <= {{(DW-1){1'b0}}, 1'b1};
      sf_last <= {DW{1'b0}};
    end else begin
      dist_valid <= a_v; // RULE_17
      if (first) begin
        dist_out <= meas_dist; // RULE_02
        sf_last <= meas_dist;
        sf_step <= sf_min;
      end else if (a_v) begin
        case (lim_m)
          `DFC_LIM_RATE: begin
            dist_out <= slew(dist_out, a_d, reg_rate[DW-1:0]); // RULE_15
          end
          `DFC_LIM_SF: begin
            // a target within 1/16 of the last one earns a doubling step; a bigger move, or reaching the target, restarts slow
            dist_out <= slew(dist_out, a_d, sf_step); // RULE_16
            sf_last <= a_d;
            if (near(a_d, sf_last) && slew(dist_out, a_d, sf_step) != a_d) begin
              sf_step <= sf_dbl; // RULE_16
            end else begin
              sf_step <= sf_min;
            end
          end
          default: begin
            dist_out <= a_d; // RULE_01
          end
        endcase
      end
    end
  end

endmodule

/* dfc_front_end.sv */
`timescale 1ns/10ps
module dfc_front_end (
  input wire clk,
  input wire srst,
  input wire go,
  input wire [15:0] d,
  output reg meas_valid,
  output reg [15:0] meas_dist
);
  // between ticks the bus toggles each cycle between the inverse of the last echo and the last echo
  always @(posedge clk) begin
    if (srst) begin
      meas_valid <= 1'b0;
      meas_dist <= 16'h0000;
    end else begin
      meas_valid <= go;
      meas_dist <= go ? d : ~meas_dist;
    end
  end
endmodule

/* dfc_properties.sv */
`timescale 1ns/10ps
module dfc_checker (
  input wire clk,
  input wire srst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire meas_valid,
  input wire poll,
  input wire dist_valid,
  input wire target_stable,
  input wire pass_busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  wire req = wb_cyc_i && wb_stb_i;
  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_answer_a: assert property (req && !wb_ack_o |=> wb_ack_o)
    else $error("request not acked next cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(req))
    else $error("ack without request");
  rdata_hold_a: assert property (!req |=> $stable(wb_dat_o))
    else $error("read data moved while idle");
  // every result, seed pass included, comes three cycles after its sample
  out_latency_a: assert property (dist_valid |-> $past(meas_valid, 3))
    else $error("result without a sample");
  unstable_quiet_a: assert property ($fell(target_stable) |-> ##2 !dist_valid)
    else $error("result from a rejected sample");
  busy_start_a: assert property (poll |=> pass_busy)
    else $error("poll did not start a pass");
  busy_end_a: assert property ($fell(pass_busy) |-> $past(meas_valid))
    else $error("pass ended without a sample");
  cover property (dist_valid);
  cover property ($fell(target_stable));
  cover property (poll && pass_busy);
endmodule

bind dfc_filter dfc_checker u_chk (.clk(clk), .srst(srst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .meas_valid(meas_valid), .poll(poll),
  .dist_valid(dist_valid), .target_stable(target_stable), .pass_busy(pass_busy));

/* distance_filter_chain_tb.sv */
`timescale 1ns/10ps
module distance_filter_chain_tb;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, poll = 1'b0, go = 1'b0, watch = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rd, r;
  logic [15:0] d = 16'h0, x, m;
  logic [31:0] bad [3] = '{32'h103, 32'h108, 32'h120};
  wire [31:0] rdat;
  wire ack, mv, dv, stab, busy;
  wire [15:0] md, dout;
  logic [15:0] q [$];
  logic [15:0] v [$];
  int n_errors = 0, n_checks = 0, seed = 93, k, s;
  always #25 clk = ~clk;
  dfc_front_end fe (.clk(clk), .srst(srst), .go(go), .d(d), .meas_valid(mv), .meas_dist(md));
  dfc_filter dut (.clk(clk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .meas_valid(mv), .meas_dist(md),
    .poll(poll), .dist_valid(dv), .dist_out(dout), .target_stable(stab), .pass_busy(busy));
  task end_of_test;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task chk_dist(input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD dist_out exp %h got %h", e, g);
    end
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [31:0] dat);
    int t;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= dat;
    t = 0;
    do begin
      @(posedge clk);
      t++;
    end while (ack !== 1'b1 && t < 20);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) begin
      n_errors++;
      end_of_test;
    end
  endtask
  task meas(input logic [15:0] val);
    @(posedge clk);
    go <= 1'b1;
    d <= val;
    @(posedge clk);
    go <= 1'b0;
    repeat (7) @(posedge clk);
  endtask
  task rnd;
    r = $random(seed);
    x = {7'h00, r[8:0]} + 16'h0190;
  endtask
  task kick;
    @(posedge clk);
    poll <= 1'b1;
    @(posedge clk);
    poll <= 1'b0;
  endtask
  task rej(input int mm, input bit far);
    for (k = 0; k < 2 * mm; k++) begin
      rnd;
      if (k % mm == 0 || (far ? x > m : x < m)) m = x;
      if (k % mm == mm - 1) q.push_back(m);
      meas(x);
    end
  endtask
  task done(input string nm);
    chk_val("left", 32'h0, q.size());
    q.delete();
    $display("test %s done", nm);
  endtask
  always @(posedge clk)
    if (watch && dv === 1'b1) begin
      chk_dist(q.size() > 0 ? q[0] : 16'hxxxx, dout);
      if (q.size() > 0) void'(q.pop_front());
    end
  initial begin
    repeat (100000) @(posedge clk);
    n_errors++;
    end_of_test;
  end
  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    wb(1'b0, 8'h00, 32'h0);
    chk_val("ctrl", 32'h00000008, rd);
    wb(1'b0, 8'h04, 32'h0);
    chk_val("rej", 32'h00074002, rd);
    wb(1'b0, 8'h08, 32'h0);
    chk_val("avg", 32'h00000032, rd);
    wb(1'b0, 8'h20, 32'h0);
    chk_val("unmapped", 32'h0, rd);
    done("registers");
    meas(16'h03e8);
    wb(1'b1, 8'h0c, 32'h5);
    wb(1'b1, 8'h00, 32'h10);
    watch <= 1'b1;
    q = '{16'h03ed, 16'h03f2, 16'h03ed};
    meas(16'h044c);
    meas(16'h044c);
    meas(16'h0384);
    done("rate");
    wb(1'b1, 8'h04, 32'h00074003);
    wb(1'b1, 8'h00, 32'h1);
    rej(3, 1'b0);
    wb(1'b1, 8'h04, 32'h00074002);
    wb(1'b1, 8'h00, 32'h2);
    rej(2, 1'b1);
    done("closest farthest");
    wb(1'b1, 8'h08, 32'h3);
    wb(1'b1, 8'h00, 32'h5);
    s = 0;
    for (k = 0; k < 6; k++) begin
      rnd;
      if (k % 2 == 0 || x < m) m = x;
      if (k % 2 == 1) s += m;
      if (k == 5) q.push_back(16'(s / 3));
      meas(x);
    end
    done("boxcar");
    wb(1'b1, 8'h08, 32'h4);
    wb(1'b1, 8'h00, 32'h8);
    for (k = 0; k < 6; k++) begin
      rnd;
      v.push_back(x);
      if (v.size() > 4) void'(v.pop_front());
      s = 0;
      foreach (v[j]) s += v[j];
      q.push_back(16'(s / v.size()));
      meas(x);
    end
    done("running");
    wb(1'b1, 8'h04, 32'h00032002);
    wb(1'b1, 8'h00, 32'h3);
    watch <= 1'b0;
    repeat (4) meas(16'h03e8);
    watch <= 1'b1;
    q = '{16'h03e8, 16'h0426, 16'h04b0};
    meas(16'h03e8);
    meas(16'h0426);
    meas(16'h04b0);
    chk_val("stable", 32'h0, {31'h0, stab});
    meas(16'h04b0);
    meas(16'h04b0);
    chk_val("stable", 32'h1, {31'h0, stab});
    done("stability");
    wb(1'b1, 8'h00, 32'h101);
    kick;
    meas(16'h03e8);
    chk_val("busy", 32'h1, {31'h0, busy});
    kick;
    q = '{16'h03e8, 16'h0384};
    meas(16'h03f2);
    chk_val("busy", 32'h1, {31'h0, busy});
    meas(16'h044c);
    meas(16'h0384);
    chk_val("busy", 32'h0, {31'h0, busy});
    foreach (bad[j]) begin
      wb(1'b1, 8'h00, bad[j]);
      wb(1'b0, 8'h14, 32'h0);
      chk_val("cfg_err", 32'h8, rd & 32'h8);
    end
    done("poll");
    wb(1'b1, 8'h0c, 32'hffffffff);
    wb(1'b0, 8'h0c, 32'h0);
    chk_val("rate", 32'h0000ffff, rd);
    wb(1'b1, 8'h10, 32'h2);
    wb(1'b1, 8'h00, 32'h20);
    q = '{16'h0384, 16'h0386, 16'h0388, 16'h038c, 16'h0394, 16'h03a4, 16'h03c4, 16'h0400};
    meas(16'h0384);
    repeat (7) meas(16'h0400);
    wb(1'b0, 8'h18, 32'h0);
    chk_val("dist", 32'h00000400, rd);
    done("slow-fast");
    end_of_test;
  end
endmodule
